// [rtl/hicq_flag_bank.sv]
// Bank of sticky event flags, set by pulses, cleared as a group.
// Assumes set pulses and the clear strobe are synchronous to clock.
`timescale 1ns/100ps
module hicq_flag_bank
#(
  parameter int WIDTH = 8                  // Number of flags
)
(
  input  wire logic             clock,     // System clock
  input  wire logic             rst,       // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] setPulse,  // One-cycle event per flag
  input  wire logic             clearAll,  // Host read strobe
  output logic      [WIDTH-1:0] flags      // Current flag state
);
  // ---------------------------------------------------------------
  // Per-flag storage
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      logic flag_ff;      // Stored flag
      logic nxt_flag_ff;  // Next flag value

      // Set beats clear so a coincident event is kept
      always_comb
      begin
        nxt_flag_ff = flag_ff;
        if (clearAll)
          nxt_flag_ff = 1'b0;  // see R5
        if (setPulse[i])
          nxt_flag_ff = 1'b1;  // see R4
      end

      // Register the flag
      always_ff @(posedge clock)
      begin
        if (rst)
          flag_ff <= 1'b0;
        else
          flag_ff <= nxt_flag_ff;
      end

      assign flags[i] = flag_ff;
    end
  endgenerate
endmodule : hicq_flag_bank

// [rtl/hicq_irq_ctrl.sv]
// Host interrupt controller and command queue pointers with AXI4-Lite registers.
// Assumes one clock, synchronous reset, and an external pull-up on the interrupt pin.
//
// Contract
// R1 - Enable low leaves interrupt pin undriven
// R2 - Enable high drives pin low on masked flag
// R3 - Mask bit one lets its flag through
// R4 - Each source sets its flag regardless
// R5 - Flag read returns flags then clears them
// R6 - Open-drain after reset, pin control selects push-pull
// R7 - Bits 7..4: sample, marker, drained, playback
// R8 - Bits 3..0: sound, tag, touch, swap
// R9 - Command queue is a 4 Kbyte buffer
// R10 - Host advances write pointer after writing commands
// R11 - Engine advances read pointer after execution
// R12 - Drained flag on pointers equal, flags sticky
`timescale 1ns/100ps
module hicq_irq_ctrl
#(
  parameter int ADDR_W = 8                      // Bus address width
)
(
  input  wire logic              clock,               // 25 MHz system clock
  input  wire logic              rst,                 // Synchronous reset, active high
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Event sources, one-cycle pulses
  input  wire logic              panelSampleDone,     // Touch conversions completed
  input  wire logic              instrQueueMarker,    // Command queue marker event
  input  wire logic              playbackEnd,         // Audio playback ended
  input  wire logic              soundEnd,            // Sound effect ended
  input  wire logic              tagChange,           // Touch tag changed
  input  wire logic              touchDetect,         // Touch detected
  input  wire logic              listSwap,            // Display list swap
  // Graphics engine side of the queue
  input  wire logic              cmdDoneValid,        // Engine finished commands
  input  wire logic [11:0]       cmdDoneBytes,        // Bytes retired
  output logic [11:0]            cmdWritePtr,         // Host write pointer
  output logic [11:0]            cmdReadPtr,          // Engine read pointer
  output logic                   cmdPending,          // Queue holds commands
  // Interrupt pin, active low
  output logic                   intPinOut,           // Driven level
  output logic                   intPinOeN            // Low while driving
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr_ff;   // Captured write address
  logic              awHave_ff, nxt_awHave_ff;   // Address held
  logic [31:0]       wData_ff, nxt_wData_ff;     // Captured write data
  logic [3:0]        wStrb_ff, nxt_wStrb_ff;     // Captured strobes
  logic              wHave_ff, nxt_wHave_ff;     // Data held
  logic              bValid_ff, nxt_bValid_ff;   // Write response pending
  logic [1:0]        bResp_ff, nxt_bResp_ff;     // Write response code
  logic              rValid_ff, nxt_rValid_ff;   // Read data pending
  logic [31:0]       rData_ff, nxt_rData_ff;     // Read data
  logic [1:0]        rResp_ff, nxt_rResp_ff;     // Read response code
  logic [7:0]        mask_ff, nxt_mask_ff;       // Interrupt mask
  logic              intEn_ff, nxt_intEn_ff;     // Global pin enable
  logic              pushPull_ff, nxt_pushPull_ff; // Pin drive mode
  logic [11:0]       wrPtr_ff, nxt_wrPtr_ff;     // Queue write pointer
  logic [11:0]       rdPtr_ff, nxt_rdPtr_ff;     // Queue read pointer
  logic              wasEmpty_ff, nxt_wasEmpty_ff; // Empty last cycle
  logic              pinOut_ff, nxt_pinOut_ff;   // Pin level
  logic              pinOeN_ff, nxt_pinOeN_ff;   // Pin enable, low drives
  logic              doWrite;                    // Address and data both held
  logic              arTake;                     // Read address taken
  logic              flagClear;                  // Host read of flags
  logic [7:0]        flags;                      // Sticky flags
  logic [7:0]        setPulse;                   // Flag set vector
  logic [11:0]       fill;                       // Bytes awaiting execution
  logic [11:0]       retire;                     // Bytes actually retired
  logic              emptyNow;                   // Pointers equal
  logic              irqActive;                  // Any masked flag

  // ---------------------------------------------------------------
  // Bus handshake outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !awHave_ff && !bValid_ff;
  assign s_axi_wready  = !wHave_ff && !bValid_ff;
  assign s_axi_arready = !rValid_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;
  assign doWrite       = awHave_ff && wHave_ff;
  assign arTake        = s_axi_arvalid && s_axi_arready;
  assign flagClear     = arTake && (s_axi_araddr == hicq_pkg::ADDR_FLAGS[ADDR_W-1:0]); // see R5

  // ---------------------------------------------------------------
  // Event mapping onto flag positions
  // ---------------------------------------------------------------
  // Source order fixed by bit position
  always_comb
  begin
    setPulse = '0;
    setPulse[hicq_pkg::BIT_PANEL_SAMPLE]  = panelSampleDone;        // see R7
    setPulse[hicq_pkg::BIT_QUEUE_MARKER]  = instrQueueMarker;       // see R7
    setPulse[hicq_pkg::BIT_QUEUE_DRAINED] = emptyNow && !wasEmpty_ff; // see R12
    setPulse[hicq_pkg::BIT_PLAYBACK_END]  = playbackEnd;            // see R7
    setPulse[hicq_pkg::BIT_SOUND_END]     = soundEnd;               // see R8
    setPulse[hicq_pkg::BIT_TAG_CHANGE]    = tagChange;              // see R8
    setPulse[hicq_pkg::BIT_TOUCH]         = touchDetect;            // see R8
    setPulse[hicq_pkg::BIT_SWAP]          = listSwap;               // see R8
  end

  // Sticky flags, set wins over read clear
  hicq_flag_bank #(.WIDTH(hicq_pkg::FLAG_W)) u_flags
  (
    .clock    (clock),
    .rst      (rst),
    .setPulse (setPulse),
    .clearAll (flagClear),
    .flags    (flags)
  );

  // ---------------------------------------------------------------
  // Command queue pointers
  // ---------------------------------------------------------------
  assign fill      = wrPtr_ff - rdPtr_ff;        // Wraps modulo 4 Kbyte, see R9
  assign emptyNow  = (fill == hicq_pkg::RST_PTR);
  assign retire    = (cmdDoneBytes > fill) ? fill : cmdDoneBytes; // No overshoot
  assign cmdWritePtr = wrPtr_ff;
  assign cmdReadPtr  = rdPtr_ff;
  assign cmdPending  = !emptyNow;

  // ---------------------------------------------------------------
  // Register and bus next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_awAddr_ff   = awAddr_ff;
    nxt_awHave_ff   = awHave_ff;
    nxt_wData_ff    = wData_ff;
    nxt_wStrb_ff    = wStrb_ff;
    nxt_wHave_ff    = wHave_ff;
    nxt_bValid_ff   = bValid_ff;
    nxt_bResp_ff    = bResp_ff;
    nxt_rValid_ff   = rValid_ff;
    nxt_rData_ff    = rData_ff;
    nxt_rResp_ff    = rResp_ff;
    nxt_mask_ff     = mask_ff;
    nxt_intEn_ff    = intEn_ff;
    nxt_pushPull_ff = pushPull_ff;
    nxt_wrPtr_ff    = wrPtr_ff;
    nxt_rdPtr_ff    = rdPtr_ff;
    nxt_wasEmpty_ff = emptyNow;
    // Capture write address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_awAddr_ff = s_axi_awaddr;
      nxt_awHave_ff = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_wData_ff = s_axi_wdata;
      nxt_wStrb_ff = s_axi_wstrb;
      nxt_wHave_ff = 1'b1;
    end
    // Perform the write once both halves are held
    if (doWrite)
    begin
      nxt_awHave_ff = 1'b0;
      nxt_wHave_ff  = 1'b0;
      nxt_bValid_ff = 1'b1;
      nxt_bResp_ff  = hicq_pkg::RESP_OKAY;
      case (awAddr_ff)
        hicq_pkg::ADDR_MASK[ADDR_W-1:0]:
        begin
          if (wStrb_ff[0])
            nxt_mask_ff = wData_ff[7:0];  // see R3
        end
        hicq_pkg::ADDR_INT_EN[ADDR_W-1:0]:
        begin
          if (wStrb_ff[0])
            nxt_intEn_ff = wData_ff[0];
        end
        hicq_pkg::ADDR_PIN_CTL[ADDR_W-1:0]:
        begin
          if (wStrb_ff[0])
            nxt_pushPull_ff = wData_ff[hicq_pkg::PIN_PUSH_PULL_BIT]; // see R6
        end
        hicq_pkg::ADDR_WR_PTR[ADDR_W-1:0]:
        begin
          // Host publishes new commands here, see R10
          if (wStrb_ff[0])
            nxt_wrPtr_ff[7:0] = wData_ff[7:0];
          if (wStrb_ff[1])
            nxt_wrPtr_ff[11:8] = wData_ff[11:8];
        end
        hicq_pkg::ADDR_FLAGS[ADDR_W-1:0],
        hicq_pkg::ADDR_RD_PTR[ADDR_W-1:0],
        hicq_pkg::ADDR_FILL[ADDR_W-1:0]:
          nxt_bResp_ff = hicq_pkg::RESP_OKAY;  // Read-only, write ignored
        default:
          nxt_bResp_ff = hicq_pkg::RESP_SLVERR; // Unmapped
      endcase
    end
    // Release write response
    if (bValid_ff && s_axi_bready)
      nxt_bValid_ff = 1'b0;
    // Engine retires executed commands only, see R11
    if (cmdDoneValid)
      nxt_rdPtr_ff = rdPtr_ff + retire;
    // Read path
    if (rValid_ff && s_axi_rready)
      nxt_rValid_ff = 1'b0;
    if (arTake)
    begin
      nxt_rValid_ff = 1'b1;
      nxt_rResp_ff  = hicq_pkg::RESP_OKAY;
      nxt_rData_ff  = 32'h0000_0000;
      case (s_axi_araddr)
        hicq_pkg::ADDR_FLAGS[ADDR_W-1:0]:   nxt_rData_ff[7:0] = flags; // see R5
        hicq_pkg::ADDR_MASK[ADDR_W-1:0]:    nxt_rData_ff[7:0] = mask_ff;
        hicq_pkg::ADDR_INT_EN[ADDR_W-1:0]:  nxt_rData_ff[0]   = intEn_ff;
        hicq_pkg::ADDR_PIN_CTL[ADDR_W-1:0]: nxt_rData_ff[hicq_pkg::PIN_PUSH_PULL_BIT] = pushPull_ff;
        hicq_pkg::ADDR_WR_PTR[ADDR_W-1:0]:  nxt_rData_ff[11:0] = wrPtr_ff;
        hicq_pkg::ADDR_RD_PTR[ADDR_W-1:0]:  nxt_rData_ff[11:0] = rdPtr_ff;
        hicq_pkg::ADDR_FILL[ADDR_W-1:0]:    nxt_rData_ff[11:0] = fill;
        default:                            nxt_rResp_ff = hicq_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pin
  // ---------------------------------------------------------------
  assign irqActive = |(flags & mask_ff);  // see R3

  // Pin drive: released, open-drain or push-pull
  always_comb
  begin
    nxt_pinOut_ff = 1'b1;
    nxt_pinOeN_ff = 1'b1;                // Undriven, pull-up wins, see R1
    if (intEn_ff)
    begin
      if (irqActive)
      begin
        nxt_pinOut_ff = 1'b0;            // see R2
        nxt_pinOeN_ff = 1'b0;
      end
      else if (pushPull_ff)
      begin
        nxt_pinOut_ff = 1'b1;            // Drive inactive high level, see R6
        nxt_pinOeN_ff = 1'b0;
      end
    end
  end

  assign intPinOut = pinOut_ff;
  assign intPinOeN = pinOeN_ff;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      awAddr_ff   <= '0;
      awHave_ff   <= 1'b0;
      wData_ff    <= 32'h0000_0000;
      wStrb_ff    <= 4'h0;
      wHave_ff    <= 1'b0;
      bValid_ff   <= 1'b0;
      bResp_ff    <= hicq_pkg::RESP_OKAY;
      rValid_ff   <= 1'b0;
      rData_ff    <= 32'h0000_0000;
      rResp_ff    <= hicq_pkg::RESP_OKAY;
      mask_ff     <= hicq_pkg::RST_MASK;
      intEn_ff    <= hicq_pkg::RST_INT_EN;
      pushPull_ff <= hicq_pkg::RST_PUSH_PULL;
      wrPtr_ff    <= hicq_pkg::RST_PTR;
      rdPtr_ff    <= hicq_pkg::RST_PTR;
      wasEmpty_ff <= 1'b1;
      pinOut_ff   <= 1'b1;
      pinOeN_ff   <= 1'b1;
    end
    else
    begin
      awAddr_ff   <= nxt_awAddr_ff;
      awHave_ff   <= nxt_awHave_ff;
      wData_ff    <= nxt_wData_ff;
      wStrb_ff    <= nxt_wStrb_ff;
      wHave_ff    <= nxt_wHave_ff;
      bValid_ff   <= nxt_bValid_ff;
      bResp_ff    <= nxt_bResp_ff;
      rValid_ff   <= nxt_rValid_ff;
      rData_ff    <= nxt_rData_ff;
      rResp_ff    <= nxt_rResp_ff;
      mask_ff     <= nxt_mask_ff;
      intEn_ff    <= nxt_intEn_ff;
      pushPull_ff <= nxt_pushPull_ff;
      wrPtr_ff    <= nxt_wrPtr_ff;
      rdPtr_ff    <= nxt_rdPtr_ff;
      wasEmpty_ff <= nxt_wasEmpty_ff;
      pinOut_ff   <= nxt_pinOut_ff;
      pinOeN_ff   <= nxt_pinOeN_ff;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_flagRead;
    flagClear && (setPulse == 8'h00);
  endsequence
  sequence s_flagsGone;
    (flags == 8'h00) && s_axi_rvalid;
  endsequence

  property p_released;
    !intEn_ff |=> intPinOeN;
  endproperty
  a_released: assert property (p_released) else $error("Pin driven while disabled"); // see R1

  property p_driveLow;
    (intEn_ff && irqActive) |=> (!intPinOeN && !intPinOut);
  endproperty
  a_driveLow: assert property (p_driveLow) else $error("Masked flag did not pull pin low"); // see R2

  property p_maskBlocks;
    (intEn_ff && !pushPull_ff && ((flags & mask_ff) == 8'h00)) |=> intPinOeN;
  endproperty
  a_maskBlocks: assert property (p_maskBlocks) else $error("Masked-off flag drove pin"); // see R3

  property p_sourceSets;
    (setPulse != 8'h00) |=> ((flags & $past(setPulse)) == $past(setPulse));
  endproperty
  a_sourceSets: assert property (p_sourceSets) else $error("Event did not set its flag"); // see R4

  property p_readClears;
    s_flagRead |=> s_flagsGone ##0 (s_axi_rdata[7:0] == $past(flags));
  endproperty
  a_readClears: assert property (p_readClears) else $error("Flag read did not return then clear"); // see R5

  property p_openDrain;
    !pushPull_ff |=> (intPinOeN || !intPinOut);
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("Open-drain pin driven high"); // see R6

  property p_drainedBit;
    (emptyNow && !wasEmpty_ff) |=> flags[hicq_pkg::BIT_QUEUE_DRAINED];
  endproperty
  a_drainedBit: assert property (p_drainedBit) else $error("Drained flag not raised"); // see R12

  property p_markerBit;
    instrQueueMarker |=> flags[hicq_pkg::BIT_QUEUE_MARKER];
  endproperty
  a_markerBit: assert property (p_markerBit) else $error("Marker flag in wrong bit"); // see R7

  property p_swapBit;
    listSwap |=> flags[hicq_pkg::BIT_SWAP];
  endproperty
  a_swapBit: assert property (p_swapBit) else $error("Swap flag in wrong bit"); // see R8

  property p_retire;
    (cmdDoneValid && !rst) |=> (rdPtr_ff == 12'($past(rdPtr_ff) + $past(retire))) &&
                               (12'(rdPtr_ff - $past(rdPtr_ff)) <= $past(fill));
  endproperty
  a_retire: assert property (p_retire) else $error("Read pointer overshot or missed"); // see R11

  property p_sticky;
    !flagClear |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_sticky: assert property (p_sticky) else $error("Flag dropped without read"); // see R12
endmodule : hicq_irq_ctrl

// [rtl/hicq_pkg.sv]
// Constants shared by the host interrupt and command queue block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses in the low 8 bits.
package hicq_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS   = 8'h00;  // Event flags, clear on read
  localparam logic [7:0] ADDR_MASK    = 8'h04;  // Per-flag enable mask
  localparam logic [7:0] ADDR_INT_EN  = 8'h08;  // Global pin enable
  localparam logic [7:0] ADDR_PIN_CTL = 8'h0C;  // Extended pin control
  localparam logic [7:0] ADDR_WR_PTR  = 8'h10;  // Queue write pointer, host owned
  localparam logic [7:0] ADDR_RD_PTR  = 8'h14;  // Queue read pointer, read only
  localparam logic [7:0] ADDR_FILL    = 8'h18;  // Queue fill level, read only

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int FLAG_W             = 8;   // Number of event flags
  localparam int BIT_PANEL_SAMPLE   = 7;   // Touch conversions completed
  localparam int BIT_QUEUE_MARKER   = 6;   // Command queue marker
  localparam int BIT_QUEUE_DRAINED  = 5;   // Command queue empty
  localparam int BIT_PLAYBACK_END   = 4;   // Audio sample playback ended
  localparam int BIT_SOUND_END      = 3;   // Sound effect ended
  localparam int BIT_TAG_CHANGE     = 2;   // Touch tag value changed
  localparam int BIT_TOUCH          = 1;   // Touch detected
  localparam int BIT_SWAP           = 0;   // Display list swap
  localparam int PIN_PUSH_PULL_BIT  = 0;   // Pin control: 1 selects push-pull
  localparam int QUEUE_BYTES        = 4096; // Command queue size, 4 Kbyte
  localparam int PTR_W              = 12;  // Byte pointer width into queue

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_FLAGS   = 8'h00;
  localparam logic [7:0]  RST_MASK    = 8'hFF;
  localparam logic        RST_INT_EN  = 1'h0;
  localparam logic        RST_PUSH_PULL = 1'h0;  // Open-drain after reset
  localparam logic [11:0] RST_PTR     = 12'h000;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hicq_pkg

// [sim/hicq_host_model.sv]
// Host side model: AXI4-Lite master making one register access at a time.
// Assumes a slave that answers when it likes; every wait is bounded.
`timescale 1ns/100ps
module hicq_host_model
(
  input  wire logic        clock,                 // System clock
  output logic      [7:0]  s_axi_awaddr  = 8'h00,
  output logic             s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata   = 32'h0000_0000,
  output logic      [3:0]  s_axi_wstrb   = 4'hf,  // Whole word always
  output logic             s_axi_wvalid  = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready  = 1'b0,
  output logic      [7:0]  s_axi_araddr  = 8'h00,
  output logic             s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready  = 1'b0
);
  // Write one word; address and data offered together, each released when taken
  task automatic writeReg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 1'b0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask : writeReg

  // Read one word at any time, flags included
  task automatic readReg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 1'b0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask : readReg
endmodule : hicq_host_model

// [sim/hicq_tb_top.sv]
// Testbench of the host interrupt and command queue block.
// Assumes the host model above and a pull-up on the interrupt wire.
`timescale 1ns/100ps
module hicq_tb_top;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  evt   = 8'h00;           // Event pulses, flag bit order
  logic        cmdDoneValid = 1'b0;
  logic [11:0] cmdDoneBytes = 12'h000;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] cmdWritePtr, cmdReadPtr;
  logic        cmdPending, intPinOut, intPinOeN;
  logic [31:0] data;
  bit          ok;
  int          n_fail  = 0;
  int          checked = 0;
  wire         intWire = intPinOeN ? 1'b1 : intPinOut;  // Pull-up when released

  // 25 MHz clock
  initial
  begin
    forever #20 clock = ~clock;
  end

  hicq_irq_ctrl hicq_irq_ctrl_inst
  (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .panelSampleDone(evt[7]),
    .instrQueueMarker(evt[6]), .playbackEnd(evt[4]), .soundEnd(evt[3]), .tagChange(evt[2]),
    .touchDetect(evt[1]), .listSwap(evt[0]), .cmdDoneValid, .cmdDoneBytes, .cmdWritePtr,
    .cmdReadPtr, .cmdPending, .intPinOut, .intPinOeN
  );

  hicq_host_model hicq_host_model_inst
  (
    .clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // Counts, verdict, end of run
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // Bus access with bounded wait, then response check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    hicq_host_model_inst.writeReg(a, d, resp, ok);
    if (!ok)
    begin
      n_fail++;
      print_verdict();
    end
    chk(32'(resp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    hicq_host_model_inst.readReg(a, data, resp, ok);
    if (!ok)
    begin
      n_fail++;
      print_verdict();
    end
    chk(data, ed);
    chk(32'(resp), 32'(er));
  endtask : rd

  // One-cycle pulse on an event or retire input
  task automatic pulse(input int idx);
    @(posedge clock);
    evt[idx] <= 1'b1;
    @(posedge clock);
    evt[idx] <= 1'b0;
  endtask : pulse

  task automatic retire(input logic [11:0] n);
    @(posedge clock);
    cmdDoneValid <= 1'b1;
    cmdDoneBytes <= n;
    @(posedge clock);
    cmdDoneValid <= 1'b0;
  endtask : retire

  // Pin enable and wire level once settled
  task automatic pinChk(input logic eoe, input logic ew);
    repeat (3) @(posedge clock);
    #1;
    chk(32'({intPinOeN, intWire}), 32'({eoe, ew}));
  endtask : pinChk

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(hicq_pkg::ADDR_MASK, 32'h0000_00ff, hicq_pkg::RESP_OKAY);
    rd(hicq_pkg::ADDR_PIN_CTL, 32'h0000_0000, hicq_pkg::RESP_OKAY);
    pinChk(1'b1, 1'b1);
    // Each source except the drained flag (bit 5) sets only its own bit; read returns it, then clears
    for (int b = 0; b < 8; b++)
    begin
      if (b != 5)
      begin
        pulse(b);
        rd(hicq_pkg::ADDR_FLAGS, 32'h0000_0001 << b, hicq_pkg::RESP_OKAY);
        rd(hicq_pkg::ADDR_FLAGS, 32'h0000_0000, hicq_pkg::RESP_OKAY);
      end
    end
    pulse(1);
    pinChk(1'b1, 1'b1);
    wr(hicq_pkg::ADDR_INT_EN, 32'h0000_0001, hicq_pkg::RESP_OKAY);
    pinChk(1'b0, 1'b0);
    wr(hicq_pkg::ADDR_MASK, 32'h0000_00fd, hicq_pkg::RESP_OKAY);
    pinChk(1'b1, 1'b1);
    wr(hicq_pkg::ADDR_PIN_CTL, 32'h0000_0001, hicq_pkg::RESP_OKAY);
    pinChk(1'b0, 1'b1);
    wr(hicq_pkg::ADDR_MASK, 32'h0000_00ff, hicq_pkg::RESP_OKAY);
    pinChk(1'b0, 1'b0);
    rd(hicq_pkg::ADDR_FLAGS, 32'h0000_0002, hicq_pkg::RESP_OKAY);
    pinChk(1'b0, 1'b1);
    // Queue: host publishes 16 bytes, engine retires 8 then more than left
    wr(hicq_pkg::ADDR_WR_PTR, 32'h0000_0010, hicq_pkg::RESP_OKAY);
    chk(32'(cmdPending), 32'h0000_0001);
    chk(32'(cmdWritePtr), 32'h0000_0010);
    rd(hicq_pkg::ADDR_FILL, 32'h0000_0010, hicq_pkg::RESP_OKAY);
    retire(12'h008);
    rd(hicq_pkg::ADDR_RD_PTR, 32'h0000_0008, hicq_pkg::RESP_OKAY);
    chk(32'(cmdReadPtr), 32'h0000_0008);
    retire(12'h020);
    rd(hicq_pkg::ADDR_RD_PTR, 32'h0000_0010, hicq_pkg::RESP_OKAY);
    repeat (4) @(posedge clock);
    rd(hicq_pkg::ADDR_FLAGS, 32'h0000_0020, hicq_pkg::RESP_OKAY);
    wr(hicq_pkg::ADDR_WR_PTR, 32'h0000_0004, hicq_pkg::RESP_OKAY);
    rd(hicq_pkg::ADDR_FILL, 32'h0000_0ff4, hicq_pkg::RESP_OKAY);
    chk(32'(cmdWritePtr), 32'h0000_0004);
    // Read-only and unmapped places
    wr(hicq_pkg::ADDR_RD_PTR, 32'h0000_0abc, hicq_pkg::RESP_OKAY);
    rd(hicq_pkg::ADDR_RD_PTR, 32'h0000_0010, hicq_pkg::RESP_OKAY);
    wr(8'h1c, 32'h0000_0001, hicq_pkg::RESP_SLVERR);
    rd(8'h1c, 32'h0000_0000, hicq_pkg::RESP_SLVERR);
    print_verdict();
  end
endmodule : hicq_tb_top
